// File: mht_defines.svh
// Constants for the measurement hold and self-timing block.
// Assumes a 100 MHz clock; included by the package and every module except mht_sync.
`ifndef MHT_DEFINES_SVH
`define MHT_DEFINES_SVH

// Clock rate in kHz
`define MHT_CLK_KHZ          100000
// Time base of the delay timer, in microseconds
`define MHT_TICK_US          1000
// Cycles per delay timer tick (1 ms at 100 MHz)
`define MHT_TICK_CYCLES      ((`MHT_CLK_KHZ * `MHT_TICK_US) / 1000)
// Longest time from reset start to outputs off, in ms
`define MHT_RESET_OFF_MS     20
// Width of detection values
`define MHT_VAL_W            24
// Width of the delay setting in ms
`define MHT_DLY_W            16
// Reset values
`define MHT_VAL_ZERO         24'h000000
`define MHT_DLY_ZERO         16'h0000
// Criterion output codes {high, go, low}
`define MHT_CRIT_OFF         3'h0
`define MHT_CRIT_ERR         3'h5
`define MHT_CRIT_HI          3'h4
`define MHT_CRIT_GO          3'h2
`define MHT_CRIT_LO          3'h1
// Status bit positions
`define MHT_EV_CAPTURE       0
`define MHT_EV_ERROR         1
`define MHT_EV_W             2

`endif

// File: mht_delay_timer.sv
// Delay timer: 1 ms tick from a divider, count compared against the setting.
// Assumes a single clock, synchronous active-low reset.
`timescale 1ns/1ps
`include "mht_defines.svh"

module mht_delay_timer
#(
    parameter int TICK_CYCLES = `MHT_TICK_CYCLES
)
(
    // Clock and reset
    input  wire logic                  ref_clk_in,
    input  wire logic                  reset_n_in,
    // Control
    input  wire logic                  start_in,
    input  wire logic                  run_in,
    input  wire logic [`MHT_DLY_W-1:0] delay_ms_in,
    // Expiry pulse
    output logic                       expire_out
);

    logic [16:0]            div_r;    // Tick divider
    logic [`MHT_DLY_W-1:0]  cnt_r;    // Elapsed ms
    wire                    tick_w = (div_r == 17'(TICK_CYCLES - 1));
    wire                    done_w = run_in && !start_in && (cnt_r >= delay_ms_in);

    // Divider and ms counter, restarted by start
    always_ff @(posedge ref_clk_in)
    begin
        if (!reset_n_in || start_in || !run_in)
        begin
            div_r <= 17'h00000;
            cnt_r <= `MHT_DLY_ZERO;
        end
        else
        begin
            div_r <= tick_w ? 17'h00000 : div_r + 17'h00001;
            if (tick_w && !done_w)
                cnt_r <= cnt_r + 16'h0001; // R16
        end
    end

    // Expiry output, high on alternate cycles while the count has reached the setting
    always_ff @(posedge ref_clk_in)
    begin
        if (!reset_n_in)
            expire_out <= 1'b0;
        else
            expire_out <= done_w && !expire_out; // R16
    end

endmodule : mht_delay_timer

// File: mht_head_model.sv
// Sensor head and timing line model: value slews to a target by a step.
// Assumes the bench commands target, step and timing level.
`timescale 1ns/1ps
`include "mht_defines.svh"

module mht_head_model
(
    input  wire logic ref_clk_in, reset_n_in, timing_cmd_in,
    input  wire logic signed [`MHT_VAL_W-1:0] target_in,
    input  wire logic [`MHT_VAL_W-1:0] step_in,
    output logic signed [`MHT_VAL_W-1:0] detect_val_out,
    output logic timing_pin_out
);
    // ********************
    // Slew logic
    // ********************
    wire signed [`MHT_VAL_W-1:0] gap = target_in - detect_val_out;  // Distance to travel
    wire [`MHT_VAL_W-1:0] mag = gap[`MHT_VAL_W-1] ? -gap : gap;    // Its magnitude

    // Step zero jumps at once, otherwise the head moves slowly
    always_ff @(posedge ref_clk_in)
    begin
        if (!reset_n_in)
        begin
            detect_val_out <= `MHT_VAL_ZERO;
            timing_pin_out <= 1'b0;
        end
        else
        begin
            timing_pin_out <= timing_cmd_in;
            if (step_in == `MHT_VAL_ZERO || mag <= step_in)
                detect_val_out <= target_in;
            else if (gap > 0)
                detect_val_out <= detect_val_out + step_in;
            else
                detect_val_out <= detect_val_out - step_in;
        end
    end
endmodule : mht_head_model

// File: mht_hold_props.sv
// Checker for the judgment and hold block, watching top ports only.
// Assumes the timing pin stays low in self-timing mode and idles low in reset.
`timescale 1ns/1ps
`include "mht_defines.svh"

module mht_hold_props
    import mht_pkg::*;
#(
    parameter int TICK_CYCLES = `MHT_TICK_CYCLES
)
(
    input  wire logic ref_clk_in, reset_n_in, timing_pin_in, reset_pin_in, reg_rd_in,
    input  wire logic [31:0] reg_rdata_out,
    input  wire mht_pkg::mht_crit_t crit_out,
    input  wire logic signed [`MHT_VAL_W-1:0] pv_out,
    input  wire logic pv_dashed_out, standby_out, error_out
);
    // ********************
    // Properties
    // ********************
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);

    // Timing held high with no reset pin activity
    sequence s_hold;
        (timing_pin_in && !reset_pin_in) [*6];
    endsequence
    // Reset pin rises while a value is held
    sequence s_pin_hit;
        $rose(reset_pin_in) && timing_pin_in;
    endsequence

    property p_err_crit;
        error_out |-> crit_out == `MHT_CRIT_ERR;
    endproperty
    property p_err_entry;
        $rose(error_out) |-> $past(crit_out) == `MHT_CRIT_OFF;
    endproperty
    property p_stby_off;
        standby_out |-> crit_out == `MHT_CRIT_OFF;
    endproperty
    property p_dash_off;
        pv_dashed_out |-> crit_out == `MHT_CRIT_OFF;
    endproperty
    property p_pin_off;
        s_pin_hit |-> ##[1:6] (crit_out == `MHT_CRIT_OFF && pv_dashed_out);
    endproperty
    property p_frozen;
        s_hold |=> $stable(pv_out) && $stable(crit_out);
    endproperty
    property p_rd_idle;
        !$past(reg_rd_in) |-> reg_rdata_out == 32'h0;
    endproperty
    property p_boot_stby;
        $rose(reset_n_in) |-> standby_out && !error_out;
    endproperty

    a_err_crit : assert property (p_err_crit) else $error("error shown without high and low");
    a_err_entry : assert property (p_err_entry) else $error("error entered from a live output");
    a_stby_off : assert property (p_stby_off) else $error("output on during standby");
    a_dash_off : assert property (p_dash_off) else $error("output on while dashed");
    a_pin_off : assert property (p_pin_off) else $error("reset pin did not clear outputs");
    a_frozen : assert property (p_frozen) else $error("held value moved");
    a_rd_idle : assert property (p_rd_idle) else $error("read data outside its cycle");
    a_boot_stby : assert property (p_boot_stby) else $error("no standby after reset");
endmodule : mht_hold_props

bind mht_hold_top mht_hold_props #(.TICK_CYCLES(TICK_CYCLES)) i_props
(
    .ref_clk_in, .reset_n_in, .timing_pin_in, .reset_pin_in, .reg_rd_in, .reg_rdata_out,
    .crit_out, .pv_out, .pv_dashed_out, .standby_out, .error_out
);

// File: mht_hold_top.sv
// Judgment and hold logic: live judgment, external timing hold,
// delay-timer self-timing with early-drop error and interrupt status.
// Assumes detection values arrive synchronous to ref_clk_in; pins are synchronised.
`timescale 1ns/1ps
`include "mht_defines.svh"

// Operation
// R1: Timing low: display and outputs track live
// R2: Timing rising edge freezes display and outputs
// R3: Frozen values ignore live value changes
// R4: Timing low releases hold, tracking resumes
// R5: Self-timing crossing: outputs off, timer starts
// R6: Delay expiry: judge, hold outputs, load display
// R7: Drop and recross: outputs off, timer restarts
// R8: Early drop: no capture, error displayed
// R9: Error: HIGH and LOW on, GO off
// R10: Error cleared by set, reset, recross
// R11: Standby indication, outputs off until capture; an early drop in standby still turns HIGH and LOW on
// R12: Hysteresis applied to self-timing level
// R13: Timing type selects rising or falling trigger
// R14: Reset input: outputs off within 20 ms, dashes
// R15: Controller spaces reset inputs 20 ms apart
// R16: Delay timer counts fixed tick against setting
module mht_hold_top
    import mht_pkg::*;
#(
    parameter int TICK_CYCLES = `MHT_TICK_CYCLES
)
(
    // Clock and reset
    input  wire logic                          ref_clk_in,
    input  wire logic                          reset_n_in,
    // Sensor head detection value
    input  wire logic signed [`MHT_VAL_W-1:0]  detect_val_in,
    // External pins (asynchronous)
    input  wire logic                          timing_pin_in,
    input  wire logic                          reset_pin_in,
    input  wire logic                          set_key_in,
    // Register port
    input  wire logic [3:0]                    reg_addr_in,
    input  wire logic [31:0]                   reg_wdata_in,
    input  wire logic                          reg_wr_in,
    input  wire logic                          reg_rd_in,
    output logic [31:0]                        reg_rdata_out,
    // Results
    output mht_pkg::mht_crit_t                 crit_out,
    output logic signed [`MHT_VAL_W-1:0]       pv_out,
    output logic                               pv_dashed_out,
    output logic                               standby_out,
    output logic                               error_out,
    output logic                               irq_out
);

    import mht_pkg::*;

    // ************************************************************
    // Register offsets (word index)
    // ************************************************************
    localparam logic [3:0] A_CTRL   = 4'h0; // [0] self-timing, [1] falling type
    localparam logic [3:0] A_UPPER  = 4'h1;
    localparam logic [3:0] A_LOWER  = 4'h2;
    localparam logic [3:0] A_HYST   = 4'h3;
    localparam logic [3:0] A_LEVEL  = 4'h4;
    localparam logic [3:0] A_DELAY  = 4'h5;
    localparam logic [3:0] A_STATUS = 4'h6;
    localparam logic [3:0] A_MASK   = 4'h7;
    localparam logic [3:0] A_STATE  = 4'h8; // Read only state view
    localparam int RST_OFF_CYC = `MHT_RESET_OFF_MS * `MHT_CLK_KHZ;

    // ************************************************************
    // Storage
    // ************************************************************
    logic                         self_mode_r;  // Self-timing select
    logic                         fall_type_r;  // Falling trigger type
    mht_tol_t                     tol_r;        // Tolerances and hysteresis
    logic signed [`MHT_VAL_W-1:0] level_r;      // Self-timing level
    logic [`MHT_DLY_W-1:0]        delay_r;      // Delay in ms
    logic [`MHT_EV_W-1:0]         status_r;     // Sticky events
    logic [`MHT_EV_W-1:0]         mask_r;       // Interrupt enables
    mht_state_t                   state_r;      // Self-timing state
    logic                         armed_r;      // Value dropped back past hysteresis, ready to trigger
    logic                         timing_d_r;   // Last synced timing level
    logic                         reset_d_r;    // Last synced reset level
    logic                         set_d_r;      // Last synced set key level

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic timing_s, reset_s, set_s;

    mht_sync u_sync_tim (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
                         .pin_in(timing_pin_in), .sync_out(timing_s));
    mht_sync u_sync_rst (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
                         .pin_in(reset_pin_in), .sync_out(reset_s));
    mht_sync u_sync_set (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
                         .pin_in(set_key_in), .sync_out(set_s));

    // ************************************************************
    // Decoding
    // ************************************************************
    // Judge a value against tolerances
    function automatic mht_crit_t judge(input logic signed [`MHT_VAL_W-1:0] v,
                                        input mht_tol_t t);
        mht_crit_t c;
        c = '0;
        if (v > t.upper)
            c.high = 1'b1;
        else if (v < t.lower)
            c.low = 1'b1;
        else
            c.go = 1'b1;
        return c;
    endfunction : judge

    wire signed [`MHT_VAL_W-1:0] hyst_s = $signed(tol_r.hyst);
    // Trigger when beyond level; re-arm needs hysteresis back
    wire above_w  = detect_val_in > level_r;                 // R12
    wire below_w  = detect_val_in < (level_r - hyst_s);      // R12
    wire under_w  = detect_val_in < level_r;                 // R12
    wire over_w   = detect_val_in > (level_r + hyst_s);      // R12
    wire trig_w   = fall_type_r ? under_w : above_w;         // R13
    wire drop_w   = fall_type_r ? over_w  : below_w;         // R13
    wire cross_w  = self_mode_r && armed_r && trig_w;        // R5 R7 R10
    wire early_w  = self_mode_r && !armed_r && drop_w && state_r == MHT_DELAY; // R8
    wire tim_rise = timing_s && !timing_d_r;                 // R2
    wire rst_rise = reset_s && !reset_d_r;                   // R14
    wire set_rise = set_s && !set_d_r;                       // R10
    wire wr_stat  = reg_wr_in && reg_addr_in == A_STATUS;
    wire expire_w;
    wire start_w  = cross_w;
    wire ev_cap   = expire_w && state_r == MHT_DELAY && !early_w;
    wire [`MHT_EV_W-1:0] ev_w = {early_w, ev_cap};

    // ************************************************************
    // Delay timer
    // ************************************************************
    mht_delay_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer
    (
        .ref_clk_in  (ref_clk_in),
        .reset_n_in  (reset_n_in),
        .start_in    (start_w),
        .run_in      (state_r == MHT_DELAY),
        .delay_ms_in (delay_r),
        .expire_out  (expire_w)                               // R16
    );

    // ************************************************************
    // Register writes
    // ************************************************************
    always_ff @(posedge ref_clk_in)
    begin
        if (!reset_n_in)
        begin
            self_mode_r <= 1'b0;
            fall_type_r <= 1'b0;
            tol_r       <= '0;
            level_r     <= `MHT_VAL_ZERO;
            delay_r     <= `MHT_DLY_ZERO;
            mask_r      <= '0;
        end
        else if (reg_wr_in)
        begin
            unique case (reg_addr_in)
                A_CTRL:  {fall_type_r, self_mode_r} <= reg_wdata_in[1:0];
                A_UPPER: tol_r.upper <= reg_wdata_in[`MHT_VAL_W-1:0];
                A_LOWER: tol_r.lower <= reg_wdata_in[`MHT_VAL_W-1:0];
                A_HYST:  tol_r.hyst  <= reg_wdata_in[`MHT_VAL_W-1:0];
                A_LEVEL: level_r     <= reg_wdata_in[`MHT_VAL_W-1:0];
                A_DELAY: delay_r     <= reg_wdata_in[`MHT_DLY_W-1:0];
                A_MASK:  mask_r      <= reg_wdata_in[`MHT_EV_W-1:0];
                default: ;
            endcase
        end
    end

    // Sticky status: set wins over write-one-to-clear
    always_ff @(posedge ref_clk_in)
    begin
        if (!reset_n_in)
            status_r <= '0;
        else
            status_r <= (status_r & ~(wr_stat ? reg_wdata_in[`MHT_EV_W-1:0] : '0)) | ev_w;
    end

    assign irq_out = |(status_r & mask_r);

    // Read data, one cycle after the strobe
    always_ff @(posedge ref_clk_in)
    begin
        if (!reset_n_in || !reg_rd_in)
            reg_rdata_out <= 32'h00000000;
        else
        begin
            unique case (reg_addr_in)
                A_CTRL:   reg_rdata_out <= {30'h0, fall_type_r, self_mode_r};
                A_UPPER:  reg_rdata_out <= {8'h00, tol_r.upper};
                A_LOWER:  reg_rdata_out <= {8'h00, tol_r.lower};
                A_HYST:   reg_rdata_out <= {8'h00, tol_r.hyst};
                A_LEVEL:  reg_rdata_out <= {8'h00, level_r};
                A_DELAY:  reg_rdata_out <= {16'h0000, delay_r};
                A_STATUS: reg_rdata_out <= {30'h0, status_r};
                A_MASK:   reg_rdata_out <= {30'h0, mask_r};
                A_STATE:  reg_rdata_out <= {27'h0, armed_r, standby_out, error_out, state_r};
                default:  reg_rdata_out <= 32'h00000000;
            endcase
        end
    end

    // ************************************************************
    // Edge history and arming
    // ************************************************************
    always_ff @(posedge ref_clk_in)
    begin
        if (!reset_n_in)
        begin
            timing_d_r <= 1'b0;
            reset_d_r  <= 1'b0;
            set_d_r    <= 1'b0;
            armed_r    <= 1'b1;
        end
        else
        begin
            timing_d_r <= timing_s;
            reset_d_r  <= reset_s;
            set_d_r    <= set_s;
            if (cross_w)
                armed_r <= 1'b0;                              // R12
            else if (drop_w)
                armed_r <= 1'b1;                              // R12
        end
    end

    // ************************************************************
    // Hold and self-timing control
    // ************************************************************
    always_ff @(posedge ref_clk_in)
    begin
        if (!reset_n_in)
        begin
            state_r       <= MHT_IDLE;
            crit_out      <= `MHT_CRIT_OFF;
            pv_out        <= `MHT_VAL_ZERO;
            pv_dashed_out <= 1'b0;
            standby_out   <= 1'b1;                            // R11
            error_out     <= 1'b0;
        end
        else if (rst_rise)
        begin
            // Reset input acts at once, well within RST_OFF_CYC
            state_r       <= MHT_IDLE;
            crit_out      <= `MHT_CRIT_OFF;                   // R14
            pv_dashed_out <= 1'b1;                            // R14
            standby_out   <= self_mode_r;                     // R11
            error_out     <= 1'b0;                            // R10
        end
        else if (!self_mode_r)
        begin
            state_r     <= MHT_IDLE;
            standby_out <= 1'b0;
            error_out   <= 1'b0;
            if (tim_rise)
                state_r <= MHT_HELD;                          // R2
            else if (!timing_s && !pv_dashed_out)
            begin
                crit_out <= judge(detect_val_in, tol_r);      // R1 R4
                pv_out   <= detect_val_in;                    // R1 R4
            end
            else if (tim_rise || (!timing_s && pv_dashed_out))
                pv_dashed_out <= 1'b0;                        // Dashes until synced timing is seen low
            // While timing high, outputs stay frozen          // R3
            if (tim_rise && !pv_dashed_out)
            begin
                crit_out <= judge(detect_val_in, tol_r);      // R2
                pv_out   <= detect_val_in;                    // R2
            end
        end
        else if (set_rise && state_r == MHT_ERROR)
        begin
            state_r     <= MHT_IDLE;                          // R10
            error_out   <= 1'b0;                              // R10
            crit_out    <= `MHT_CRIT_OFF;                     // R11
            standby_out <= 1'b1;                              // R11
        end
        else if (cross_w)
        begin
            state_r   <= MHT_DELAY;                           // R5 R7
            crit_out  <= `MHT_CRIT_OFF;                       // R5 R7
            error_out <= 1'b0;                                // R10
        end
        else if (early_w)
        begin
            state_r   <= MHT_ERROR;                           // R8
            crit_out  <= `MHT_CRIT_ERR;                       // R9
            error_out <= 1'b1;                                // R8
        end
        else if (ev_cap)
        begin
            state_r       <= MHT_HELD;
            crit_out      <= judge(detect_val_in, tol_r);     // R6
            pv_out        <= detect_val_in;                   // R6
            pv_dashed_out <= 1'b0;
            standby_out   <= 1'b0;                            // R11
        end
    end

endmodule : mht_hold_top

// File: mht_hold_top_test.sv
// Self-checking bench for the judgment and hold block.
// Assumes the head model drives detection value and timing pin.
`timescale 1ns/1ps
`include "mht_defines.svh"

module mht_hold_top_test;
    import mht_pkg::*;
    // ********************
    // Signals
    // ********************
    localparam int TICKS = 10;  // Short tick keeps delays brief
    logic        ref_clk_in, reset_n_in, timing_cmd_in, timing_pin_in, reset_pin_in, set_key_in;
    logic        reg_wr_in, reg_rd_in, pv_dashed_out, standby_out, error_out, irq_out;
    logic [3:0]  reg_addr_in;
    logic [31:0] reg_wdata_in, reg_rdata_out, rdata;  // rdata: last read word
    logic [`MHT_VAL_W-1:0] step_in;
    logic signed [`MHT_VAL_W-1:0] target_in, detect_val_in, pv_out, v, pvh;  // v: target, pvh: held
    mht_crit_t   crit_out;
    int          n, seed = 91938, miscompares = 0, samples_checked = 0;
    int          corner [4] = '{1000, 1001, -1000, -1001};

    mht_head_model i_head (.ref_clk_in, .reset_n_in, .target_in, .step_in, .timing_cmd_in,
        .detect_val_out(detect_val_in), .timing_pin_out(timing_pin_in));
    mht_hold_top #(.TICK_CYCLES(TICKS)) i_dut (.ref_clk_in, .reset_n_in, .detect_val_in,
        .timing_pin_in, .reset_pin_in, .set_key_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
        .reg_rd_in, .reg_rdata_out, .crit_out, .pv_out, .pv_dashed_out, .standby_out,
        .error_out, .irq_out);

    // ********************
    // Helpers
    // ********************
    // Expected criterion with upper 1000 and lower -1000
    function automatic mht_crit_t judge(input logic signed [`MHT_VAL_W-1:0] x);
        return (x > 1000) ? `MHT_CRIT_HI : (x < -1000) ? `MHT_CRIT_LO : `MHT_CRIT_GO;
    endfunction : judge

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out

    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk_in);
        #1;
    endtask : cyc

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b0;
        #1;
        rdata = reg_rdata_out;
    endtask : rd

    task automatic put(input logic signed [`MHT_VAL_W-1:0] x, input logic [`MHT_VAL_W-1:0] s);
        @(posedge ref_clk_in);
        target_in <= x;
        step_in <= s;
        v = x;
    endtask : put

    task automatic tim(input logic b);
        @(posedge ref_clk_in);
        timing_cmd_in <= b;
    endtask : tim

    // Waits for a capture, bounded
    task automatic wait_cap;
        n = 0;
        while (crit_out === `MHT_CRIT_OFF && n < 300)
        begin
            cyc(1);
            n++;
        end
        if (n >= 300)
        begin
            miscompares++;
            $display("[ERR] capture expected done seen timeout");
            close_out();
        end
    endtask : wait_cap

    // Early drop leaves the error state set
    task automatic drop_early;
        put(0, 0); cyc(6);
        put(600, 0); cyc(10);
        put(0, 0); cyc(6);
    endtask : drop_early

    // ********************
    // Sequence
    // ********************
    initial
    begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    initial
    begin
        {reset_n_in, timing_cmd_in, reset_pin_in, set_key_in, reg_wr_in, reg_rd_in} = 6'h00;
        target_in = 24'h000000; step_in = 24'h000000; reg_addr_in = 4'h0; reg_wdata_in = 32'h0;
        repeat (10) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        cyc(1);
        rd(4'h8); chk("state", rdata & 32'hC, 32'h0);
        wr(4'h1, 32'h3E8); wr(4'h2, 32'hFFFFFC18); wr(4'h4, 32'h1F4); wr(4'h5, 32'h3); wr(4'h7, 32'h3);
        rd(4'h1); chk("upper", rdata, 32'h3E8);
        wr(4'h9, 32'h5A); rd(4'h9); chk("unmapped", rdata, 32'h0);
        // Standard mode tracking, corners then random values
        for (int i = 0; i < 10; i++)
        begin
            put((i < 4) ? corner[i] : $random(seed) % 4000, 0); cyc(6);
            chk("pv", pv_out, v);
            chk("crit", crit_out, judge(v));
        end
        put(1001, 0); tim(1); cyc(6);
        repeat (4)
        begin
            put($random(seed) % 4000, 0); cyc(3);
            chk("pv", pv_out, 24'sd1001);
            chk("crit", crit_out, `MHT_CRIT_HI);
        end
        tim(0); cyc(6); chk("pv", pv_out, v);
        tim(1); cyc(6);
        @(posedge ref_clk_in) reset_pin_in <= 1'b1;
        cyc(3);
        @(posedge ref_clk_in) reset_pin_in <= 1'b0;
        cyc(6); chk("crit", crit_out, `MHT_CRIT_OFF); chk("dashed", pv_dashed_out, 1'b1);
        tim(0); cyc(6); chk("dashed", pv_dashed_out, 1'b0);
        // Self-timing, rising trigger, slow head
        wr(4'h3, 32'h10); wr(4'h0, 32'h1); wr(4'h6, 32'h3); put(0, 0); cyc(6); pvh = pv_out;
        put(2000, 200); cyc(6);
        chk("crit", crit_out, `MHT_CRIT_OFF); chk("pv", pv_out, pvh);
        wait_cap(); chk("delay_len", (n >= 20 && n <= 40), 1'b1);
        chk("crit", crit_out, `MHT_CRIT_HI); chk("pv", pv_out, 24'sd2000);
        chk("irq", irq_out, 1'b1); wr(4'h6, 32'h1); chk("irq", irq_out, 1'b0);
        drop_early();
        chk("error", error_out, 1'b1); chk("pv", pv_out, 24'sd2000);
        chk("crit", crit_out, `MHT_CRIT_ERR);
        rd(4'h6); chk("status", rdata, 32'h2);
        wr(4'h7, 32'h1); chk("irq", irq_out, 1'b0); wr(4'h7, 32'h3); wr(4'h6, 32'h2);
        put(600, 0); cyc(6);
        chk("error", error_out, 1'b0);
        chk("crit", crit_out, `MHT_CRIT_OFF); chk("pv", pv_out, 24'sd2000);
        wait_cap(); chk("crit", crit_out, `MHT_CRIT_GO); chk("pv", pv_out, 24'sd600);
        put(490, 0); cyc(6); put(600, 0); cyc(6); chk("crit", crit_out, `MHT_CRIT_GO);
        put(480, 0); cyc(6); put(600, 0); cyc(6); chk("crit", crit_out, `MHT_CRIT_OFF);
        wait_cap();
        drop_early();
        @(posedge ref_clk_in) set_key_in <= 1'b1;
        cyc(3);
        @(posedge ref_clk_in) set_key_in <= 1'b0;
        cyc(8); chk("error", error_out, 1'b0);
        chk("standby", standby_out, 1'b1); chk("crit", crit_out, `MHT_CRIT_OFF);
        // Falling trigger
        put(500, 0); cyc(6); wr(4'h0, 32'h3); put(-2000, 0); cyc(6);
        chk("crit", crit_out, `MHT_CRIT_OFF);
        wait_cap(); chk("crit", crit_out, `MHT_CRIT_LO); chk("pv", pv_out, -24'sd2000);
        close_out();
    end
endmodule : mht_hold_top_test

// File: mht_pkg.sv
// Types of the measurement hold and self-timing block.
// Assumes mht_defines.svh is in the include path.
`include "mht_defines.svh"

package mht_pkg;

    // Criterion outputs
    typedef struct packed {
        logic high;
        logic go;
        logic low;
    } mht_crit_t;

    // Judgment settings
    typedef struct packed {
        logic signed [`MHT_VAL_W-1:0] upper;
        logic signed [`MHT_VAL_W-1:0] lower;
        logic        [`MHT_VAL_W-1:0] hyst;
    } mht_tol_t;

    // Self-timing states (Gray along the path)
    typedef enum logic [1:0] {
        MHT_IDLE  = 2'h0,
        MHT_DELAY = 2'h1,
        MHT_HELD  = 2'h3,
        MHT_ERROR = 2'h2
    } mht_state_t;

endpackage : mht_pkg

// File: mht_sync.sv
// Two-flop synchroniser for pin inputs.
// Assumes a single clock, synchronous active-low reset.
`timescale 1ns/1ps

module mht_sync
(
    // Clock and reset
    input  wire logic ref_clk_in,
    input  wire logic reset_n_in,
    // Pin and result
    input  wire logic pin_in,
    output logic      sync_out
);

    logic meta_r;   // First stage, read only by the second

    // Two stages
    always_ff @(posedge ref_clk_in)
    begin
        if (!reset_n_in)
        begin
            meta_r   <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta_r   <= pin_in;
            sync_out <= meta_r;
        end
    end

endmodule : mht_sync
